// ---- rtl/ptcr_pkg.sv ----
/*
  constants, enumerations and carrier types of the pattern trigger and clock routing block.
  assumes a single 200 MHz clock and a plain register port driven by local software logic.
*/
package ptcr_pkg;

  // ---------------------------------------------------------------
  // sizes and clock rate
  // ---------------------------------------------------------------
  localparam int unsigned PTCR_AW      = 8;    // register address width
  localparam int unsigned PTCR_DW      = 32;   // register data width
  localparam int unsigned PTCR_NLINE   = 8;    // trigger bus lines and digital lines
  localparam int unsigned PTCR_DIO_W   = 16;   // digital mask word width
  localparam int unsigned PTCR_CLK_NS  = 5;    // clock period in ns

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] PTCR_OFS_CTRL   = 8'h00;  // mode, timer, role, soft trigger
  localparam logic [7:0] PTCR_OFS_EVSEL  = 8'h04;  // event out / in line
  localparam logic [7:0] PTCR_OFS_CKSEL  = 8'h08;  // sample clock in / out line
  localparam logic [7:0] PTCR_OFS_BMASK  = 8'h0C;  // bus condition masks, 4 x 8
  localparam logic [7:0] PTCR_OFS_DMASK0 = 8'h10;  // digital rise / fall masks
  localparam logic [7:0] PTCR_OFS_DMASK1 = 8'h14;  // digital high / low masks
  localparam logic [7:0] PTCR_OFS_TPER   = 8'h18;  // timer period in cycles
  localparam logic [7:0] PTCR_OFS_STAT   = 8'h1C;  // read-only state
  localparam logic [7:0] PTCR_OFS_BDIR   = 8'h20;  // bus line direction, 1 = output

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned PTCR_CTRL_PAT  = 0;   // pattern trigger mode enable
  localparam int unsigned PTCR_CTRL_TMR  = 1;   // internal timer source enable
  localparam int unsigned PTCR_CTRL_ROLE = 2;   // 1 = sample clock master
  localparam int unsigned PTCR_CTRL_SOFT = 3;   // write 1 = software trigger
  localparam int unsigned PTCR_SEL_OUT   = 0;   // lsb of out select field
  localparam int unsigned PTCR_SEL_IN    = 8;   // lsb of in select field
  localparam int unsigned PTCR_ST_DIO    = 8;   // lsb of digital levels in status
  localparam int unsigned PTCR_ST_OK     = 16;  // pattern satisfied
  localparam int unsigned PTCR_ST_SCLK   = 17;  // selected sample clock level
  localparam int unsigned PTCR_ST_CNT    = 24;  // lsb of event counter

  // condition mask indices
  localparam int unsigned PTCR_M_RISE = 0;
  localparam int unsigned PTCR_M_FALL = 1;
  localparam int unsigned PTCR_M_HIGH = 2;
  localparam int unsigned PTCR_M_LOW  = 3;

  // sample clock line codes
  localparam logic [3:0] PTCR_LINE_0    = 4'h0;
  localparam logic [3:0] PTCR_LINE_4    = 4'h4;
  localparam logic [3:0] PTCR_LINE_NONE = 4'h8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned PTCR_TMR_NS   = 1000;  // default timer period in ns
  localparam int unsigned PTCR_TMR_CYC  = PTCR_TMR_NS / PTCR_CLK_NS;
  localparam int unsigned PTCR_SCLK_NS  = 50;    // default sample clock half period
  localparam int unsigned PTCR_SCLK_CYC = PTCR_SCLK_NS / PTCR_CLK_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {PTCR_SLAVE, PTCR_MASTER} ptcr_role_t;

  typedef struct packed {
    logic                 we;     // write strobe
    logic                 re;     // read strobe
    logic [PTCR_AW-1:0]   addr;   // byte address
    logic [PTCR_DW-1:0]   wdata;  // write data
  } ptcr_req_t;

  typedef struct packed {
    logic [PTCR_NLINE-1:0] level;  // value driven on each bus line
    logic [PTCR_NLINE-1:0] oe_n;   // low while the line is driven
  } ptcr_drv_t;

endpackage : ptcr_pkg

// ---- rtl/ptcr_core.sv ----
/*
  pattern trigger combiner and sample clock router with its register file.
  assumes bus and digital lines arrive asynchronously and software owns the register port.
*/
// Local design decisions: the register offsets and the plain strobed port.
// Operation
// - event needs every configured line condition
// - conditions within one line are ored
// - sources bus, digital, timer, software trigger
// - four 8-bit bus masks, bit per line
// - mask index rise, fall, high, low
// - digital falling mask sits at index one
// - digital masks 16-bit, eight low bits used
// - timer gives periodic events only when enabled
// - event driven on selectable bus line
// - effective trigger from separate input line
// - sample clock role master or slave
// - clock input line 0, 4 or internal
// - clock output select only in master
// - master clock in and out may differ
module ptcr_core
  import ptcr_pkg::*;
#(
  parameter int unsigned NLINE    = PTCR_NLINE,
  parameter int unsigned TMR_CYC  = PTCR_TMR_CYC,
  parameter int unsigned SCLK_CYC = PTCR_SCLK_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire ptcr_req_t        req,
  output logic [PTCR_DW-1:0]    rdata,
  input  wire logic [NLINE-1:0] bus_in,
  output ptcr_drv_t             bus_drv,
  input  wire logic [NLINE-1:0] dio_in,
  output logic                  trig_event,
  output logic                  sample_clk
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [3:0]             ctrl_r;        // pattern, timer, role (soft is a pulse)
  logic [2:0]             ev_out_sel_r;  // event_out_line_select
  logic [2:0]             ev_in_sel_r;   // event_in_line_select
  logic [3:0]             ck_in_sel_r;   // clock_in_line_select
  logic [3:0]             ck_out_sel_r;  // clock_out_line_select
  logic [3:0][7:0]        bmask_r;       // bus_line_condition_masks
  logic [3:0][15:0]       dmask_r;       // digital condition masks
  logic [31:0]            tper_r;        // timer period in cycles
  logic [NLINE-1:0]       bdir_r;        // bus line direction
  logic [PTCR_DW-1:0]     rdata_r;       // read answer
  logic                   soft_r;        // software trigger pulse
  logic                   wr_ctrl;       // write to control word
  ptcr_role_t             role;          // sample clock role

  assign wr_ctrl = req.we && (req.addr == PTCR_OFS_CTRL);
  assign role    = ctrl_r[PTCR_CTRL_ROLE] ? PTCR_MASTER : PTCR_SLAVE;

  // configuration writes; reset leaves every source off and clock lines internal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r       <= 4'h0;
      ev_out_sel_r <= 3'h0;
      ev_in_sel_r  <= 3'h0;
      ck_in_sel_r  <= PTCR_LINE_NONE;
      ck_out_sel_r <= PTCR_LINE_NONE;
      bmask_r      <= '0;
      dmask_r      <= '0;
      tper_r       <= 32'(TMR_CYC);
      bdir_r       <= '0;
    end else if (req.we) begin
      unique case (req.addr)
        PTCR_OFS_CTRL: begin
          // soft bit is not stored, it only fires a pulse
          ctrl_r <= {1'b0, req.wdata[PTCR_CTRL_ROLE:0]};
        end
        PTCR_OFS_EVSEL: begin
          ev_out_sel_r <= req.wdata[PTCR_SEL_OUT +: 3];
          ev_in_sel_r  <= req.wdata[PTCR_SEL_IN +: 3];
        end
        PTCR_OFS_CKSEL: begin
          ck_in_sel_r  <= req.wdata[PTCR_SEL_IN +: 4];
          ck_out_sel_r <= req.wdata[PTCR_SEL_OUT +: 4];
        end
        PTCR_OFS_BMASK:  bmask_r   <= req.wdata;
        PTCR_OFS_DMASK0: dmask_r[1:0] <= req.wdata;
        PTCR_OFS_DMASK1: dmask_r[3:2] <= req.wdata;
        PTCR_OFS_TPER:   tper_r    <= req.wdata;
        PTCR_OFS_BDIR:   bdir_r    <= req.wdata[NLINE-1:0];
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end
  end

  // software trigger has no enable of its own but fires an event only while pattern mode is on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_r <= 1'b0;
    end else begin
      soft_r <= wr_ctrl && req.wdata[PTCR_CTRL_SOFT];
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers and filtered levels
  // ---------------------------------------------------------------
  localparam int unsigned NIN = 2 * NLINE;
  logic [NIN-1:0] s1_r, s2_r, s3_r;  // three-stage chain
  logic [NIN-1:0] filt_r;            // accepted level
  logic [NIN-1:0] filt_q_r;          // previous accepted level
  logic [NIN-1:0] agree;             // stages two and three agree

  assign agree = ~(s2_r ^ s3_r);

  // the first stage only feeds the second, a level counts once stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      filt_r   <= '0;
      filt_q_r <= '0;
    end else begin
      s1_r     <= {dio_in, bus_in};
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      filt_r   <= (s2_r & agree) | (filt_r & ~agree);
      filt_q_r <= filt_r;
    end
  end

  // ---------------------------------------------------------------
  // per-line condition evaluation
  // ---------------------------------------------------------------
  logic [NIN-1:0] line_ok;  // line satisfied or not configured
  logic [NIN-1:0] line_cfg; // line carries at least one condition

  for (genvar i = 0; i < NIN; i++) begin : g_line
    logic [3:0] msk;  // enabled conditions
    logic [3:0] ev;   // conditions present this cycle
    if (i < NLINE) begin : g_bus
      assign msk = {bmask_r[PTCR_M_LOW][i], bmask_r[PTCR_M_HIGH][i],
                    bmask_r[PTCR_M_FALL][i], bmask_r[PTCR_M_RISE][i]};
    end else begin : g_dio
      // only the low eight bits of each 16-bit digital mask are defined
      assign msk = {dmask_r[PTCR_M_LOW][i-NLINE], dmask_r[PTCR_M_HIGH][i-NLINE],
                    dmask_r[PTCR_M_FALL][i-NLINE], dmask_r[PTCR_M_RISE][i-NLINE]};
    end
    // order follows the mask index: rise, fall, high, low
    assign ev = {~filt_r[i], filt_r[i],
                 ~filt_r[i] & filt_q_r[i], filt_r[i] & ~filt_q_r[i]};
    assign line_cfg[i] = |msk;
    assign line_ok[i]  = ~line_cfg[i] | |(msk & ev);
  end

  // ---------------------------------------------------------------
  // internal timer
  // ---------------------------------------------------------------
  logic [31:0] tcnt_r;  // cycles since the last tick
  logic        tick;    // periodic timer event
  logic        tmr_en;  // timer source enabled

  assign tmr_en = ctrl_r[PTCR_CTRL_TMR];
  // a zero period behaves as one cycle rather than stalling
  assign tick   = tmr_en && (tcnt_r + 32'h1 >= tper_r);

  // counter is held at zero while disabled so enabling starts a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_r <= 32'h0;
    end else if (!tmr_en || tick) begin
      tcnt_r <= 32'h0;
    end else begin
      tcnt_r <= tcnt_r + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // combined pattern event
  // ---------------------------------------------------------------
  logic       pat_en;    // pattern trigger mode
  logic       any_cfg;   // some condition is configured
  logic       all_ok;    // each configured line has a condition holding
  logic       all_q_r;   // all_ok one cycle back
  logic       evt_r;     // combined event pulse
  logic       evt_q_r;   // event one cycle back, stretches the line level
  logic       evt_nxt;
  logic [7:0] ecnt_r;    // events fired, wraps

  assign pat_en  = ctrl_r[PTCR_CTRL_PAT];
  assign any_cfg = |line_cfg | tmr_en;
  // nothing configured must not fire every cycle, so an empty pattern never matches
  assign all_ok  = any_cfg && (&line_ok) && (!tmr_en || tick);
  assign evt_nxt = pat_en && ((all_ok && !all_q_r) || soft_r);

  // event pulse, match history and counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      all_q_r <= 1'b0;
      evt_r   <= 1'b0;
      evt_q_r <= 1'b0;
      ecnt_r  <= 8'h00;
    end else begin
      all_q_r <= all_ok;
      evt_r   <= evt_nxt;
      evt_q_r <= evt_r;
      if (evt_nxt) begin
        ecnt_r <= ecnt_r + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // sample clock generation and selection
  // ---------------------------------------------------------------
  logic [15:0] sdiv_r;   // half-period divider
  logic        sgen_r;   // generated sample clock
  logic        int_line; // internal sample clock line
  logic        sclk_sel; // selected clock source
  logic        sclk_r;

  // divider runs free; only a master routes the result anywhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdiv_r <= 16'h0000;
      sgen_r <= 1'b0;
    end else if (sdiv_r + 16'h0001 >= 16'(SCLK_CYC)) begin
      sdiv_r <= 16'h0000;
      sgen_r <= ~sgen_r;
    end else begin
      sdiv_r <= sdiv_r + 16'h0001;
    end
  end

  // out select of none puts the master clock on the internal line
  assign int_line = (role == PTCR_MASTER) && (ck_out_sel_r >= PTCR_LINE_NONE)
                    && sgen_r;

  // input select holds in both roles; any code but 0 or 4 means internal
  always_comb begin
    unique case (ck_in_sel_r)
      PTCR_LINE_0: sclk_sel = filt_r[0];
      PTCR_LINE_4: sclk_sel = filt_r[4];
      default:     sclk_sel = int_line;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
    end else begin
      sclk_r <= sclk_sel;
    end
  end

  // ---------------------------------------------------------------
  // bus line drive and event input
  // ---------------------------------------------------------------
  logic [NLINE-1:0] lvl_r;   // driven levels
  logic [NLINE-1:0] oe_n_r;  // low while driving
  logic             trig_r;  // effective trigger pulse
  logic             ein;     // selected event input level
  logic             ein_q;

  // event line wins over a clock routed to the same line
  for (genvar i = 0; i < NLINE; i++) begin : g_drv
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lvl_r[i]  <= 1'b0;
        oe_n_r[i] <= 1'b1;
      end else begin
        oe_n_r[i] <= ~bdir_r[i];
        if (ev_out_sel_r == 3'(i)) begin
          // two cycles high: a one-cycle level never passes a listener's input filter,
          // our own loopback included, so the event would be lost on the wire
          lvl_r[i] <= evt_r || evt_q_r;
        end else if (role == PTCR_MASTER && ck_out_sel_r == 4'(i)) begin
          lvl_r[i] <= sgen_r;
        end else begin
          lvl_r[i] <= 1'b0;
        end
      end
    end
  end

  assign ein   = filt_r[ev_in_sel_r];
  assign ein_q = filt_q_r[ev_in_sel_r];

  // a loop through a hub returns the event on a line of its own choosing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= ein && !ein_q;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (req.re) begin
      rdata_r <= '0;
      unique case (req.addr)
        PTCR_OFS_CTRL:   rdata_r[PTCR_CTRL_ROLE:0] <= ctrl_r[PTCR_CTRL_ROLE:0];
        PTCR_OFS_EVSEL: begin
          rdata_r[PTCR_SEL_OUT +: 3] <= ev_out_sel_r;
          rdata_r[PTCR_SEL_IN +: 3]  <= ev_in_sel_r;
        end
        PTCR_OFS_CKSEL: begin
          rdata_r[PTCR_SEL_OUT +: 4] <= ck_out_sel_r;
          rdata_r[PTCR_SEL_IN +: 4]  <= ck_in_sel_r;
        end
        PTCR_OFS_BMASK:  rdata_r <= bmask_r;
        PTCR_OFS_DMASK0: rdata_r <= dmask_r[1:0];
        PTCR_OFS_DMASK1: rdata_r <= dmask_r[3:2];
        PTCR_OFS_TPER:   rdata_r <= tper_r;
        PTCR_OFS_BDIR:   rdata_r[NLINE-1:0] <= bdir_r;
        PTCR_OFS_STAT: begin
          rdata_r[NLINE-1:0]               <= filt_r[NLINE-1:0];
          rdata_r[PTCR_ST_DIO +: NLINE]    <= filt_r[NIN-1:NLINE];
          rdata_r[PTCR_ST_OK]              <= all_ok;
          rdata_r[PTCR_ST_SCLK]            <= sclk_r;
          rdata_r[PTCR_ST_CNT +: 8]        <= ecnt_r;
        end
        default: begin
          // unmapped reads return zero
        end
      endcase
    end else begin
      rdata_r <= '0;  // answer stands for one cycle only
    end
  end

  assign rdata         = rdata_r;
  assign bus_drv.level = lvl_r;
  assign bus_drv.oe_n  = oe_n_r;
  assign trig_event    = trig_r;
  assign sample_clk    = sclk_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_soft_wr;
    wr_ctrl && req.wdata[PTCR_CTRL_SOFT] && req.wdata[PTCR_CTRL_PAT];
  endsequence
  sequence s_fire_out;
    ##1 evt_r ##1 lvl_r[ev_out_sel_r];
  endsequence

  chk_event_all_ok: assert property (evt_r |-> $past(pat_en) &&
      ($past(soft_r) || $past(all_ok))) else $error("event without full match");
  chk_line_or: assert property (bmask_r[PTCR_M_HIGH][1] && filt_r[1] |-> line_ok[1])
    else $error("high level not accepted on bus line 1");
  chk_soft_fire: assert property (s_soft_wr |=> ##1 evt_r)
    else $error("software trigger lost");
  chk_rise_only: assert property (bmask_r[PTCR_M_RISE][5] && !line_ok[5] |-> !(filt_r[5]
      && !filt_q_r[5])) else $error("rising edge not accepted");
  chk_timer_off: assert property (!tmr_en |-> !tick ##1 tcnt_r == 32'h0)
    else $error("timer ticks while disabled");
  chk_event_out: assert property (!evt_r && evt_nxt && $stable(ev_out_sel_r)
      && !req.we |-> s_fire_out) else $error("event missing on out line");
  chk_trig_in: assert property (trig_event |-> $past(ein) && !$past(ein_q))
    else $error("trigger without input rise");
  chk_slave_clk: assert property (role == PTCR_SLAVE |-> !int_line)
    else $error("slave drives internal clock line");
  chk_clk_in_sel: assert property (ck_in_sel_r == PTCR_LINE_4 |=> sclk_r == $past(filt_r[4]))
    else $error("sample clock not from line 4");
  chk_single_pulse: assert property (evt_r && !$past(soft_r) |=> !evt_r || $past(soft_r))
    else $error("event wider than one cycle");

endmodule : ptcr_core

// ---- testbench/ptcr_peer.sv ----
/*
  trigger bus peer: other instruments plus a hub that echoes one line onto another.
  assumes the device drives a line only while its oe_n bit is low.
*/
module ptcr_peer
  import ptcr_pkg::*;
(
  input  wire logic       clk,
  input  wire ptcr_drv_t  drv,
  input  wire logic [7:0] peer_val,
  input  wire logic       hub_on,
  input  wire logic [2:0] hub_src,
  input  wire logic [2:0] hub_dst,
  output logic [7:0]      bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lvl_w;  // resolved level of each line
  logic       hub_r;  // hub echo, one clock late like a real hub
  // ---------------------------------------------------------------
  // line resolution: the device wins only where it drives
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_w[i] = drv.oe_n[i] ? peer_val[i] : drv.level[i];
    end
  end
  always_ff @(posedge clk) begin
    hub_r <= lvl_w[hub_src];
  end
  always_comb begin
    bus_in = lvl_w;
    if (hub_on) begin
      bus_in[hub_dst] = hub_r;  // echo replaces the far instrument's level
    end
  end
endmodule : ptcr_peer

// ---- testbench/testbench.sv ----
/*
  self-checking bench of the pattern trigger and clock router.
  assumes TMR_CYC 4 and SCLK_CYC 2 so timer and clock runs stay short.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ptcr_pkg::*;
  logic clk, rst_n, trig_event, sample_clk, hub_on;
  ptcr_req_t req;  // register request
  ptcr_drv_t bus_drv;  // device line drive
  logic [31:0] rdata, d, c0, c1;
  logic [7:0] bus_in, dio_in, peer_val;
  logic [2:0] hub_src, hub_dst;
  int miscompares, n_checks, cycles, lv, tr, sc;
  ptcr_core #(.TMR_CYC(4), .SCLK_CYC(2)) DUT (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .bus_in(bus_in), .bus_drv(bus_drv), .dio_in(dio_in),
    .trig_event(trig_event), .sample_clk(sample_clk));
  ptcr_peer PEER (.clk(clk), .drv(bus_drv), .peer_val(peer_val), .hub_on(hub_on),
    .hub_src(hub_src), .hub_dst(hub_dst), .bus_in(bus_in));
  // ---------------------------------------------------------------
  // clock, hang guard, shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;  // the run hung
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    req.we <= 1'h1; req.addr <= a; req.wdata <= v;
    @(posedge clk);
    req.we <= 1'h0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    req.re <= 1'h1; req.addr <= a;
    @(posedge clk);
    req.re <= 1'h0;
    #1 v = rdata;  // data stand only in this cycle
  endtask : rd
  // counts cycles with line ls driven high, trigger high, sample clock high
  task automatic watch(int n, int ls);
    lv = 0; tr = 0; sc = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      lv += (bus_drv.level[ls] === 1'b1);
      tr += (trig_event === 1'b1);
      sc += (sample_clk === 1'b1);
    end
  endtask : watch
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_soft();
    wr(PTCR_OFS_BDIR, 32'h4);
    wr(PTCR_OFS_EVSEL, 32'h602);
    check("oe_n_dir", 32'hFB, 32'(bus_drv.oe_n));
    hub_on <= 1'b1;  // out line 2 comes back on line 6
    wr(PTCR_OFS_CTRL, 32'h8);  // soft write with pattern mode off
    watch(20, 2);
    check("soft_off", 0, lv + tr);
    wr(PTCR_OFS_CTRL, 32'h9);
    watch(20, 2);
    check("evt_line", 2, lv);
    check("trig_back", 1, tr);
    rd(PTCR_OFS_CTRL, d);
    check("soft_rd0", 32'h1, d);
  endtask : t_soft
  task automatic t_and_or();
    peer_val[1] <= 1'b1; dio_in[3] <= 1'b1;
    wr(PTCR_OFS_BMASK, 32'h20000);  // bus line 1 high
    wr(PTCR_OFS_DMASK1, 32'h80000);  // digital line 3 low
    repeat (6) @(posedge clk);
    rd(PTCR_OFS_STAT, d);
    check("and_miss", 0, d[16]);
    dio_in[3] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(PTCR_OFS_STAT, d);
    check("and_hit", 1, d[16]);
    wr(PTCR_OFS_BMASK, 32'h2020000);  // line 1 high or low
    peer_val[1] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(PTCR_OFS_STAT, d);
    check("or_line", 1, d[16]);
    wr(PTCR_OFS_BMASK, 32'h0);
    wr(PTCR_OFS_DMASK1, 32'h0);
  endtask : t_and_or
  // one mask index on bus line 5 or digital lines 0 and 3: one event
  task automatic t_edge(bit dio, logic [1:0] k);
    logic [7:0] a;
    a = dio ? (k[1] ? PTCR_OFS_DMASK1 : PTCR_OFS_DMASK0) : PTCR_OFS_BMASK;
    @(posedge clk);
    if (dio) begin dio_in[0] <= k[0]; dio_in[3] <= k[0]; end
    else peer_val[5] <= k[0];  // fall and low start high
    repeat (6) @(posedge clk);
    wr(a, dio ? 32'h9 << (16 * k[0]) : 32'h20 << (8 * k));
    repeat (6) @(posedge clk);
    rd(PTCR_OFS_STAT, c0);
    @(posedge clk);
    if (dio) begin dio_in[0] <= !k[0]; dio_in[3] <= !k[0]; end
    else peer_val[5] <= !k[0];
    repeat (8) @(posedge clk);
    rd(PTCR_OFS_STAT, c1);
    check(dio ? "dio_cond" : "bus_cond", 1, 8'(c1[31:24] - c0[31:24]));
    wr(a, 32'h0);
  endtask : t_edge
  task automatic t_timer();
    peer_val[5] <= 1'b1;
    wr(PTCR_OFS_BMASK, 32'h200000);
    repeat (6) @(posedge clk);
    rd(PTCR_OFS_STAT, c0);
    repeat (40) @(posedge clk);
    rd(PTCR_OFS_STAT, c1);
    check("tmr_off", 0, 8'(c1[31:24] - c0[31:24]));
    wr(PTCR_OFS_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    rd(PTCR_OFS_STAT, c0);
    check("tmr_on", 1, 8'(c0[31:24] - c1[31:24]) >= 5);
    wr(PTCR_OFS_CTRL, 32'h0);
    wr(PTCR_OFS_BMASK, 32'h0);
  endtask : t_timer
  task automatic t_sclk();
    wr(PTCR_OFS_CTRL, 32'h4);  // standalone master, both selects none
    watch(40, 4);
    check("int_clk", 1, sc > 10 && sc < 30);
    check("no_out", 0, lv);
    wr(PTCR_OFS_CKSEL, 32'h408);  // in line 4 held low
    watch(20, 4);
    check("in_line4", 0, sc);
    hub_src <= 3'h4; hub_dst <= 3'h0;
    wr(PTCR_OFS_BDIR, 32'h10);
    wr(PTCR_OFS_CKSEL, 32'h4);  // out 4, back in on 0
    watch(40, 4);
    check("out_line4", 1, lv > 10 && lv < 30);
    check("in_line0", 1, sc > 10 && sc < 30);
    hub_on <= 1'b0; peer_val[0] <= 1'b1;
    wr(PTCR_OFS_CTRL, 32'h0);  // slave ignores the out select
    repeat (6) @(posedge clk);
    watch(20, 4);
    check("slv_out", 0, lv);
    check("slv_in", 20, sc);
  endtask : t_sclk
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    req = '0; rst_n = 1'b0; dio_in = '0; peer_val = '0; hub_on = 1'b0;
    hub_src = 3'h2; hub_dst = 3'h6; miscompares = 0; n_checks = 0; cycles = 0;
    repeat (2) @(posedge clk);
    #1 check("rst_rdata", 0, rdata);
    check("rst_oe_n", 32'hFF, 32'(bus_drv.oe_n));
    check("rst_lines", 0, {22'h0, bus_drv.level, trig_event, sample_clk});
    @(posedge clk) rst_n <= 1'b1;
    rd(PTCR_OFS_CKSEL, d);
    check("ck_rst", 32'h808, d);
    @(posedge clk) #1 check("rd_once", 0, rdata);
    rd(PTCR_OFS_TPER, d);
    check("tper_rst", 4, d);
    rd(8'h40, d);
    check("unmapped", 0, d);
    t_soft();
    wr(PTCR_OFS_CTRL, 32'h1);
    t_and_or();
    for (int k = 0; k < 8; k++) t_edge(k[2], k[1:0]);
    t_timer();
    t_sclk();
    print_verdict();
  end
endmodule : testbench
